// file: rtl/sar_seq_pkg.sv
package sar_seq_pkg;
  // control byte field positions
  localparam int unsigned PWR_HI_BIT = 7;
  localparam int unsigned PWR_LO_BIT = 6;
  localparam int unsigned ACQ_BIT = 5;
  localparam int unsigned PAIR_BIT = 4;
  localparam int unsigned POL_BIT = 3;
  localparam int unsigned CH_MSB = 2;
  localparam int unsigned CH_LSB = 0;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned FIFO_DEPTH = 32;
  // power/clock codes
  localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'hc0;
  // timing in conversion-clock cycles
  localparam logic [3:0] CONV_CYCLES = 4'hd;
  localparam logic [3:0] ACQ_CYCLES = 4'h3;
  localparam logic [2:0] HOLD_FALL_EDGE = 3'h4;
  // internal oscillator: 13 cycles in 3.6 us
  localparam int unsigned CORE_PERIOD_PS = 50000;
  localparam int unsigned CONV_TIME_PS = 3600000;
  localparam logic [6:0] OSC_WRAP = 7'(CONV_TIME_PS / CORE_PERIOD_PS);
  localparam logic [6:0] OSC_STEP = 7'(2 * CONV_CYCLES);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CONV
  } seq_state_t;
endpackage

// file: rtl/result_if.sv
`timescale 1ns/1ps
`default_nettype none
interface result_if;
  logic valid;
  logic ready;
  logic [11:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/result_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
    end
  end
endmodule
`default_nettype wire

// file: rtl/sar_adc_acquisition_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_acquisition_sequencer
  import sar_seq_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // host port pins
  input wire logic DEV_SEL_N_I,
  input wire logic STORE_N_I,
  input wire logic FETCH_N_I,
  input wire logic UPPER_BYTE_SELECT_I,
  input wire logic CONV_CLK_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_O,
  output logic DONE_N_O,
  // analog front-end controls
  output logic TRACK_O,
  output logic [2:0] CHANNEL_SELECT_O,
  output logic INPUT_PAIRING_SELECT_O,
  output logic POLARITY_SELECT_O,
  output logic [1:0] POWER_MODE_O,
  output logic SAR_STEP_O,
  // comparator result bit per step
  input wire logic COMP_I
);
  // three-stage pin synchronisers
  logic [2:0] sel_s;
  logic [2:0] wr_s;
  logic [2:0] rd_s;
  logic [2:0] ck_s;
  logic [2:0] hb_s;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sel_s <= 3'h7;
      wr_s <= 3'h7;
      rd_s <= 3'h7;
      ck_s <= 3'h0;
      hb_s <= 3'h0;
    end else begin
      sel_s <= {sel_s[1:0], DEV_SEL_N_I};
      wr_s <= {wr_s[1:0], STORE_N_I};
      rd_s <= {rd_s[1:0], FETCH_N_I};
      ck_s <= {ck_s[1:0], CONV_CLK_I};
      hb_s <= {hb_s[1:0], UPPER_BYTE_SELECT_I};
    end
  end

  // filtered levels: change once stages two and three agree
  logic sel_n_r;
  logic wr_n_r;
  logic rd_n_r;
  logic ck_r;
  logic hb_r;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sel_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      ck_r <= 1'b0;
      hb_r <= 1'b0;
    end else begin
      if (sel_s[1] == sel_s[2]) sel_n_r <= sel_s[2];
      if (wr_s[1] == wr_s[2]) wr_n_r <= wr_s[2];
      if (rd_s[1] == rd_s[2]) rd_n_r <= rd_s[2];
      if (ck_s[1] == ck_s[2]) ck_r <= ck_s[2];
      if (hb_s[1] == hb_s[2]) hb_r <= hb_s[2];
    end
  end

  // data bus is sampled while the strobe is low; settled by the rising edge
  logic [7:0] wdata_r;
  logic wr_d_r;
  logic rd_d_r;
  logic ck_d_r;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wdata_r <= 8'h00;
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
      ck_d_r <= 1'b0;
    end else begin
      if (!STORE_N_I && !DEV_SEL_N_I) wdata_r <= DATA_I;
      wr_d_r <= wr_n_r;
      rd_d_r <= rd_n_r;
      ck_d_r <= ck_r;
    end
  end

  logic write_ev;
  logic read_ev;
  logic ext_rise;
  logic ext_fall;
  assign write_ev = !sel_n_r && wr_n_r && !wr_d_r;
  assign read_ev = !sel_n_r && !rd_n_r && rd_d_r;
  assign ext_rise = !sel_n_r && ck_r && !ck_d_r;
  assign ext_fall = !sel_n_r && !ck_r && ck_d_r;

  // control byte
  logic [7:0] ctrl_r;
  logic ext_clk_r;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_r <= CTRL_RESET;
    end else if (write_ev) begin
      ctrl_r <= wdata_r;
    end
  end

  // power codes 00/01 keep the last clock source
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ext_clk_r <= 1'b1;
    end else if (write_ev && wdata_r[PWR_HI_BIT]) begin
      ext_clk_r <= wdata_r[PWR_LO_BIT];
    end
  end

  // internal oscillator: phase accumulator, half periods of 2 or 3 core cycles,
  // so thirteen periods span the whole conversion time with no rounding
  logic [6:0] osc_acc_r;
  logic [6:0] osc_sum;
  logic osc_tick;
  logic osc_r;
  logic osc_rise;
  logic osc_fall;
  assign osc_sum = osc_acc_r + OSC_STEP;
  assign osc_tick = (osc_sum >= OSC_WRAP) && !write_ev;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      osc_acc_r <= 7'h00;
      osc_r <= 1'b0;
    end else if (write_ev) begin
      osc_acc_r <= 7'h00;
      osc_r <= 1'b0;
    end else if (osc_tick) begin
      osc_acc_r <= osc_sum - OSC_WRAP;
      osc_r <= !osc_r;
    end else begin
      osc_acc_r <= osc_sum;
    end
  end
  assign osc_rise = osc_tick && !osc_r;
  assign osc_fall = osc_tick && osc_r;

  // selected conversion clock edges
  logic clk_rise;
  logic clk_fall;
  assign clk_rise = ext_clk_r ? ext_rise : osc_rise;
  assign clk_fall = ext_clk_r ? ext_fall : osc_fall;

  logic powered;
  assign powered = ctrl_r[PWR_HI_BIT];

  // sequencer
  seq_state_t state_r;
  logic [3:0] cyc_r;
  logic [11:0] sar_r;
  logic [11:0] result_r;
  logic done_n_r;
  logic conv_done;
  assign conv_done = state_r == ST_CONV && clk_fall && cyc_r == CONV_CYCLES - 4'h1;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
      cyc_r <= 4'h0;
    end else if (write_ev) begin
      cyc_r <= 4'h0;
      if (!ctrl_r[ACQ_BIT] || state_r != ST_ACQ || wdata_r[ACQ_BIT]) begin
        state_r <= ST_ACQ;
      end else begin
        state_r <= ST_CONV;
      end
    end else begin
      case (state_r)
        ST_ACQ: begin
          if (!ctrl_r[ACQ_BIT] && clk_fall) begin
            if (cyc_r == {1'b0, HOLD_FALL_EDGE} - 4'h1) begin
              state_r <= ST_CONV;
              cyc_r <= 4'h0;
            end else begin
              cyc_r <= cyc_r + 4'h1;
            end
          end
        end
        ST_CONV: begin
          if (clk_fall) begin
            if (conv_done) begin
              state_r <= ST_IDLE;
            end else begin
              cyc_r <= cyc_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // sar register; one bit decided per rising edge
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sar_r <= 12'h000;
    end else if (write_ev) begin
      sar_r <= 12'h000;
    end else if (state_r == ST_CONV && clk_rise && cyc_r < CONV_CYCLES - 4'h1) begin
      sar_r <= {sar_r[10:0], COMP_I};
    end
  end

  // result fifo; the host reads the oldest unread result, a full fifo drops new ones
  result_if res_if ();
  logic fifo_valid;
  logic [11:0] fifo_data;
  assign res_if.valid = conv_done && powered;
  assign res_if.data = sar_r;

  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .flush_i(1'b0),
    .in_valid_i(res_if.valid),
    .in_ready_o(res_if.ready),
    .in_data_i(res_if.data),
    .out_valid_o(fifo_valid),
    .out_ready_i(read_ev && hb_r),
    .out_data_o(fifo_data)
  );

  // last result, shown again once the fifo is drained
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      result_r <= 12'h000;
    end else if (conv_done && powered) begin
      result_r <= sar_r;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      done_n_r <= 1'b1;
    end else if (conv_done && powered) begin
      done_n_r <= 1'b0;
    end else if (read_ev || write_ev) begin
      done_n_r <= 1'b1;
    end
  end

  // read data mux
  logic [11:0] rd_src;
  logic [7:0] rd_byte;
  assign rd_src = fifo_valid ? fifo_data : result_r;
  always_comb begin
    if (hb_r) begin
      rd_byte = {{4{rd_src[11] & !ctrl_r[POL_BIT]}}, rd_src[11:8]};
    end else begin
      rd_byte = rd_src[7:0];
    end
  end

  // outputs
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DATA_O <= 8'h00;
      DATA_OE_O <= 1'b0;
      DONE_N_O <= 1'b1;
      TRACK_O <= 1'b0;
      CHANNEL_SELECT_O <= 3'h0;
      INPUT_PAIRING_SELECT_O <= 1'b0;
      POLARITY_SELECT_O <= 1'b0;
      POWER_MODE_O <= PWR_EXT_CLK;
      SAR_STEP_O <= 1'b0;
    end else begin
      DATA_O <= rd_byte;
      DATA_OE_O <= !sel_n_r && !rd_n_r;
      DONE_N_O <= done_n_r;
      TRACK_O <= state_r == ST_ACQ;
      CHANNEL_SELECT_O <= ctrl_r[CH_MSB:CH_LSB];
      INPUT_PAIRING_SELECT_O <= ctrl_r[PAIR_BIT];
      POLARITY_SELECT_O <= ctrl_r[POL_BIT];
      POWER_MODE_O <= ctrl_r[PWR_HI_BIT:PWR_LO_BIT];
      SAR_STEP_O <= state_r == ST_CONV && clk_rise;
    end
  end

  // checks
  property p_done_after_conv;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (conv_done && powered && !write_ev) |=> ##1 !DONE_N_O;
  endproperty
  a_done_after_conv: assert property (p_done_after_conv) else $error("flag not low after conversion");

  property p_done_clear;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (read_ev && !(conv_done && powered)) |=> ##1 DONE_N_O;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("flag not cleared by read");

  property p_write_tracks;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (write_ev && wdata_r[ACQ_BIT]) |=> ##1 TRACK_O;
  endproperty
  a_write_tracks: assert property (p_write_tracks) else $error("no tracking after write");

  property p_ext_clk_reset;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (write_ev && wdata_r[PWR_HI_BIT:PWR_LO_BIT] == PWR_INT_CLK) |=> !ext_clk_r;
  endproperty
  a_ext_clk_reset: assert property (p_ext_clk_reset) else $error("clock source not internal");

  property p_keep_clk;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (write_ev && !wdata_r[PWR_HI_BIT]) |=> $stable(ext_clk_r);
  endproperty
  a_keep_clk: assert property (p_keep_clk) else $error("power-down changed clock source");

  property p_int_ignores_ext;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (!ext_clk_r && ext_fall && !osc_fall) |-> !clk_fall;
  endproperty
  a_int_ignores_ext: assert property (p_int_ignores_ext) else $error("external clock used");

  property p_deselect_quiet;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      sel_n_r |=> !DATA_OE_O;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("bus driven while deselected");

  property p_abort;
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
      (write_ev && state_r == ST_CONV) |=> state_r == ST_ACQ;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
endmodule
`default_nettype wire

// file: tb/adc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module adc_far_side (
  // core side
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [11:0] val_i,
  input wire logic step_i,
  // pins
  output logic conv_clk_o,
  output logic comp_o
);
  logic [11:0] sh_r;
  initial conv_clk_o = 1'b0;
  // 1 MHz at 50% duty; held low when off, as a tied pin would be
  always #500 conv_clk_o = run_i ? ~conv_clk_o : 1'b0;
  // refill with inverted bits so stale steps never repeat a value
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      sh_r <= val_i;
    end else if (step_i) begin
      sh_r <= {sh_r[10:0], ~sh_r[11]};
    end
  end
  assign comp_o = sh_r[11];
endmodule
`default_nettype wire

// file: tb/sar_adc_acquisition_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_acquisition_sequencer_tb_top import sar_seq_pkg::*;;
  logic clk, rstn, sel_n, st_n, fe_n, ub, oe, done_n, trk, pair, pol, step, cclk, comp, run, ld;
  logic [7:0] din, dout, b;
  logic [2:0] ch;
  logic [1:0] pm;
  logic [11:0] r, lv;
  logic [7:0] q[$];
  int error_cnt, checks_done, falls, f0, n, seed;

  always #25 clk = ~clk;
  always @(negedge cclk) falls++;

  sar_adc_acquisition_sequencer dut (
    .CORE_CLK_I(clk), .RESETN_I(rstn), .DEV_SEL_N_I(sel_n), .STORE_N_I(st_n),
    .FETCH_N_I(fe_n), .UPPER_BYTE_SELECT_I(ub), .CONV_CLK_I(cclk), .DATA_I(din),
    .DATA_O(dout), .DATA_OE_O(oe), .DONE_N_O(done_n), .TRACK_O(trk),
    .CHANNEL_SELECT_O(ch), .INPUT_PAIRING_SELECT_O(pair), .POLARITY_SELECT_O(pol),
    .POWER_MODE_O(pm), .SAR_STEP_O(step), .COMP_I(comp)
  );
  adc_far_side host (
    .clk_i(clk), .run_i(run), .load_i(ld), .val_i(lv), .step_i(step),
    .conv_clk_o(cclk), .comp_o(comp)
  );

  task automatic check(input logic [11:0] s, input logic [11:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // bounded wait, sampled mid-cycle where outputs are settled
  task automatic wt(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    check({11'h0, s}, {11'h0, v});
  endtask

  // aligned just after a clock fall so edge counts are exact
  // select stays low: the conversion clock only counts while selected
  task automatic wr(input logic [7:0] v);
    if (run) @(negedge cclk);
    @(posedge clk);
    sel_n <= 1'b0;
    st_n <= 1'b0;
    din <= v;
    repeat (4) @(posedge clk);
    st_n <= 1'b1;
    repeat (4) @(posedge clk);
    din <= ~v;
  endtask

  task automatic rd(input logic u, input logic [7:0] e);
    q.push_back(e);
    @(posedge clk);
    sel_n <= 1'b0;
    fe_n <= 1'b0;
    ub <= u;
    wt(oe, 1'b1, 20);
    repeat (4) @(posedge clk);
    fe_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic rdres(input logic [11:0] v, input logic uni);
    rd(1'b0, v[7:0]);
    check({11'h0, done_n}, 12'h1);
    rd(1'b1, uni ? {4'h0, v[11:8]} : {{4{v[11]}}, v[11:8]});
  endtask

  task automatic go(input logic [7:0] v, input logic [11:0] res);
    wr(v);
    wt(trk, 1'b1, 20);
    f0 = falls;
    check({9'h0, ch}, {9'h0, v[CH_MSB:CH_LSB]});
    check({11'h0, pair}, {11'h0, v[PAIR_BIT]});
    check({11'h0, pol}, {11'h0, v[POL_BIT]});
    @(posedge clk);
    ld <= 1'b1;
    lv <= res;
    @(posedge clk);
    ld <= 1'b0;
  endtask

  task automatic conv_done(input logic [11:0] v, input logic uni);
    f0 = falls;
    wt(done_n, 1'b0, 400);
    check(12'(falls - f0), 12'hd);
    rdres(v, uni);
  endtask

  always @(posedge oe) begin
    repeat (2) @(negedge clk);
    check({4'h0, dout}, {4'h0, q.pop_front()});
  end

  initial begin
    #(50 * 20000);
    error_cnt++;
    conclude();
  end

  initial begin
    seed = 22058;
    clk = 0;
    rstn = 0;
    sel_n = 1;
    st_n = 1;
    fe_n = 1;
    ub = 0;
    din = 8'h00;
    run = 1;
    ld = 0;
    lv = 12'h000;
    cyc(5);
    rstn = 1;
    cyc(4);
    check({11'h0, done_n}, 12'h1);
    check({10'h0, pm}, {10'h0, PWR_EXT_CLK});
    // deselected strobes change nothing
    @(posedge clk);
    st_n <= 1'b0;
    fe_n <= 1'b0;
    din <= 8'h80;
    cyc(6);
    check({11'h0, oe}, 12'h0);
    @(posedge clk);
    st_n <= 1'b1;
    fe_n <= 1'b1;
    cyc(20);
    check({11'h0, trk}, 12'h0);
    check({10'h0, pm}, {10'h0, PWR_EXT_CLK});
    $display("test reset and deselect done");
    for (int k = 0; k < 2; k++) begin
      r = 12'($random(seed));
      b = {PWR_EXT_CLK, 1'b0, 5'($random(seed))};
      b[POL_BIT] = k[0];
      go(b, r);
      wt(trk, 1'b0, 200);
      check(12'(falls - f0), 12'h4);
      conv_done(r, b[POL_BIT]);
    end
    $display("test internal acquisition done");
    r = 12'($random(seed));
    b = {PWR_EXT_CLK, 1'b1, 5'($random(seed))};
    go(b, r);
    cyc(200);
    check({11'h0, trk}, 12'h1);
    b[ACQ_BIT] = 1'b0;
    wr(b);
    wt(trk, 1'b0, 10);
    conv_done(r, b[POL_BIT]);
    $display("test external acquisition done");
    go(b, 12'($random(seed)));
    wt(trk, 1'b0, 200);
    cyc(60);
    r = 12'($random(seed));
    go(b, r);
    check({11'h0, done_n}, 12'h1);
    wt(trk, 1'b0, 200);
    conv_done(r, b[POL_BIT]);
    $display("test abort done");
    // at once, so the next write never waits on a stopped clock
    run = 1'b0;
    r = 12'($random(seed));
    b = {PWR_INT_CLK, 1'b0, 5'($random(seed))};
    go(b, r);
    check({10'h0, pm}, {10'h0, PWR_INT_CLK});
    wt(trk, 1'b0, 100);
    n = 0;
    while (done_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(12'(n >= 60 && n <= 75), 12'h1);
    rdres(r, b[POL_BIT]);
    run <= 1'b1;
    $display("test internal clock done");
    for (int p = 0; p < 4; p++) begin
      wr({p[1:0], 6'h20});
      cyc(8);
      check({10'h0, pm}, 12'(p));
    end
    $display("test power codes done");
    conclude();
  end
endmodule
`default_nettype wire
